//--- dv/pab_backend_test.sv
// Self-checking bench for the dual pipeline converter back end.
`timescale 1ns/10ps
`default_nettype none
module pab_backend_test;
    import pab_pkg::*;
    typedef struct {int t; logic [WORD_W-1:0] a; logic [WORD_W-1:0] b; bit timed;} pab_note_t;
    logic                core_clk = 1'b0;
    logic                rst_n    = 1'b0;
    logic                hold_off = 1'b0;
    logic [RAW_W-1:0]    codes_a  = '0;
    logic [RAW_W-1:0]    codes_b  = '0;
    logic [15:0]         seed     = 16'h1d70;
    logic                capture_ready, phase_sample, phase_hold, word_strobe, data_valid, overrun;
    logic                got_word, got_valid;
    logic [WORD_W-1:0]   out_a, out_b;
    logic [2*WORD_W-1:0] got_pair;
    logic [RAW_W-1:0]    mem_a [64];
    logic [RAW_W-1:0]    mem_b [64];
    pab_note_t           notes [$];
    int cyc = 0, k = -1, last_s = -100, mode = 0, strobes = 0, num_errors = 0, comparisons = 0;
    bit timed = 1, checking = 1;

    // A sample every four core cycles sits far above the minimum conversion rate.
    always #4 core_clk = ~core_clk;
    always @(posedge core_clk) cyc <= cyc + 1;

    pab_backend uut (.core_clk(core_clk), .rst_n(rst_n), .chan_a_stage_codes(codes_a),
        .chan_b_stage_codes(codes_b), .capture_ready(capture_ready), .phase_sample(phase_sample),
        .phase_hold(phase_hold), .chan_a_output_bits(out_a), .chan_b_output_bits(out_b),
        .word_strobe(word_strobe), .data_valid(data_valid), .overrun(overrun));
    pab_capture_model capture (.core_clk(core_clk), .rst_n(rst_n), .hold_off(hold_off),
        .capture_ready(capture_ready), .word_strobe(word_strobe), .data_valid(data_valid),
        .chan_a_output_bits(out_a), .chan_b_output_bits(out_b), .got_word(got_word),
        .got_valid(got_valid), .got_pair(got_pair));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] lfsr(logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    // Reference correction: stages 0..7 clamp at two, weighted by position.
    function automatic logic [WORD_W-1:0] correct(logic [RAW_W-1:0] c);
        logic [10:0] v;
        v = {9'h000, c[17:16]};
        for (int s = 0; s < 8; s++) v += 11'(c[2*s+1] ? 2'h2 : c[2*s +: 2]) << (8 - s);
        return v[9:0];
    endfunction

    // Directed corners of the code table between random samples.
    function automatic logic [RAW_W-1:0] pick(int n, logic [RAW_W-1:0] r);
        case (n % 8)
            0: return {STAGES{CODE_TOP}};
            1: return 18'h0_0002;
            2: return 18'h0_0000;
            3: return 18'h3_fffd;
            default: return r;
        endcase
    endfunction

    task automatic check_word(string what, logic [WORD_W-1:0] exp, logic [WORD_W-1:0] got);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_bit(string what, logic exp, logic got);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Stimulus: each stage field carries the sample whose turn it is at the next phase end.
    // ------------------------------------------------------------
    always @(negedge core_clk) begin
        logic [RAW_W-1:0] ra, rb;
        seed = lfsr(seed);
        ra = {seed[1:0], seed};
        seed = lfsr(seed);
        rb = {seed[1:0], seed};
        hold_off <= (mode == 2) || (mode == 1 && seed[4:2] == 3'h0);
        if (!rst_n) begin
            k = -1;
        end else if (phase_sample === 1'b1) begin
            k = k + 1;
            mem_a[k % 64] = pick(k, ra);
            mem_b[k % 64] = pick(k + 3, rb);
            notes.push_back('{cyc + 26, correct(mem_a[k % 64]), correct(mem_b[k % 64]), timed});
        end
        for (int s = 0; s < STAGES; s++) begin
            int j;
            j = (phase_hold === 1'b1 && s % 2 == 0) ? k - s / 2 :
                (phase_sample === 1'b1 && s % 2 == 1) ? k - (s + 1) / 2 : -1;
            codes_a[2*s +: 2] <= (j >= 0) ? mem_a[j % 64][2*s +: 2] : ra[2*s +: 2];
            codes_b[2*s +: 2] <= (j >= 0) ? mem_b[j % 64][2*s +: 2] : rb[2*s +: 2];
        end
    end

    // ------------------------------------------------------------
    // Monitor: oldest note against each captured pair.
    // ------------------------------------------------------------
    always @(negedge core_clk) begin
        pab_note_t n;
        if (!rst_n) last_s = -100;
        if (phase_sample === 1'b1) last_s = cyc;
        check_bit("phase overlap", 1'b0, phase_sample & phase_hold);
        if (phase_hold === 1'b1 && last_s >= 0) check_bit("hold after sample", 1'b1, cyc - last_s == 2);
        if (got_word === 1'b1) begin
            strobes++;
            if (k < 18 || k > 20) check_bit("warm-up valid", k > 20, got_valid);
            if (checking && got_valid !== 1'b1) begin
                if (notes.size() > 0 && notes[0].t <= cyc) void'(notes.pop_front());
            end else if (checking && notes.size() == 0) begin
                check_bit("note present", 1'b1, 1'b0);
            end else if (checking) begin
                n = notes.pop_front();
                if (n.timed) check_bit("word on time", 1'b1, cyc == n.t);
                check_word("channel a", n.a, got_pair[9:0]);
                check_word("channel b", n.b, got_pair[19:10]);
            end
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(negedge core_clk);
        check_word("a in reset", 10'h000, out_a);
        check_bit("valid in reset", 1'b0, data_valid);
        rst_n <= 1'b1;
        for (int i = 0; i < 200 && got_valid !== 1'b1; i++) @(negedge core_clk);
        if (got_valid !== 1'b1) begin
            num_errors++;
            summarize();
        end
        repeat (160) @(negedge core_clk);
        timed = 0;
        mode = 1;
        repeat (160) @(negedge core_clk);
        mode = 0;
        repeat (120) @(negedge core_clk);
        checking = 0;
        mode = 2;
        repeat (32) @(negedge core_clk);
        strobes = 0;
        repeat (96) @(negedge core_clk);
        check_bit("strobe while stalled", 1'b1, strobes == 0);
        check_bit("overrun", 1'b1, overrun);
        rst_n <= 1'b0;
        @(negedge core_clk);
        check_bit("overrun cleared", 1'b0, overrun);
        notes.delete();
        checking = 1;
        timed = 1;
        mode = 0;
        repeat (4) @(negedge core_clk);
        rst_n <= 1'b1;
        repeat (160) @(negedge core_clk);
        check_bit("notes drained", 1'b1, notes.size() < 10);
        summarize();
    end
endmodule
`default_nettype wire

//--- dv/pab_capture_model.sv
// Model of the downstream capture logic that takes the sample word pairs.
`timescale 1ns/10ps
`default_nettype none
module pab_capture_model (
    // Clock and reset.
    input  wire logic                          core_clk,
    input  wire logic                          rst_n,
    // Bench request to stop taking words.
    input  wire logic                          hold_off,
    // Converter side.
    output logic                               capture_ready,
    input  wire logic                          word_strobe,
    input  wire logic                          data_valid,
    input  wire logic [pab_pkg::WORD_W-1:0]    chan_a_output_bits,
    input  wire logic [pab_pkg::WORD_W-1:0]    chan_b_output_bits,
    // Captured pair, one cycle after the strobe.
    output logic                               got_word,
    output logic                               got_valid,
    output logic [2*pab_pkg::WORD_W-1:0]       got_pair
);
    // Ready moves only off the sampling edge, as real capture logic would.
    initial capture_ready = 1'b1;
    always @(negedge core_clk) capture_ready <= ~hold_off;

    // Both words are taken on one strobe edge as a single pair.
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            got_word  <= 1'b0;
            got_valid <= 1'b0;
            got_pair  <= '0;
        end else begin
            got_word  <= word_strobe;
            got_valid <= data_valid;
            if (word_strobe) got_pair <= {chan_b_output_bits, chan_a_output_bits};
        end
    end
endmodule
`default_nettype wire

//--- shared/pab_pkg.sv
// Package of constants and types for the dual pipeline converter digital back end.
//
// Overview of operation
// - Derive a non-overlapping two-phase clock, sample and hold, from the master clock.
// - Take the sample as the sample phase ends; the hold phase follows after one gap cycle.
// - Each channel has eight two-bit stages and a final two-bit ninth stage.
// - Adjacent stages run in opposite phases; alternate stages act together.
// - Every stage's two-bit word enters a delay line advanced by the internal clock.
// - The delay line aligns all nine stage codes of one sample into eighteen bits.
// - Correction uses the redundant bits to produce one ten-bit result per sample.
// - A sample's word reaches the output after the sixth sampling cycle.
// - After the latency, one new output word appears every sampling cycle.
// - Output is offset binary, bit 9 the MSB, all ones at positive full scale.
// - Two independent channels share the one sampling clock.
// - Output words are invalid until twenty sampling cycles have run after power-up.
package pab_pkg;

    // -----------------------------------------------------------------
    // Geometry of the pipeline
    // -----------------------------------------------------------------
    localparam int unsigned STAGES       = 9;
    localparam int unsigned CODE_W       = 2;
    localparam int unsigned RAW_W        = STAGES * CODE_W;
    localparam int unsigned WORD_W       = 10;
    localparam int unsigned LINE_DEPTH   = 9;
    localparam int unsigned CHANNELS     = 2;

    // -----------------------------------------------------------------
    // Counts in sampling cycles and buffer sizing
    // -----------------------------------------------------------------
    localparam int unsigned LATENCY_CYCLES = 6;
    localparam logic [4:0]  WARMUP_CYCLES  = 5'h14;
    localparam int unsigned FIFO_DEPTH     = 16;

    // -----------------------------------------------------------------
    // Code values
    // -----------------------------------------------------------------
    localparam logic [1:0]        CODE_TOP  = 2'h3;
    localparam logic [1:0]        CODE_MAX  = 2'h2;
    localparam logic [WORD_W-1:0] WORD_FULL = 10'h3ff;
    localparam logic [WORD_W-1:0] WORD_MID  = 10'h200;

    // Phase sequencer: one core clock per state, four per sampling cycle.
    typedef enum logic [1:0] {
        PH_SAMPLE,
        PH_GAP_A,
        PH_HOLD,
        PH_GAP_B
    } pab_phase_t;

endpackage

//--- verilog/pab_backend.sv
// Dual-channel pipeline converter back end: phase clocks, delay line, correction, output.
`timescale 1ns/10ps
`default_nettype none
module pab_backend (
    // Clock and reset.
    input  wire logic                               core_clk,
    input  wire logic                               rst_n,
    // Raw stage codes, stage i in bits [2i+1:2i], from the comparator latches.
    input  wire logic [pab_pkg::RAW_W-1:0]          chan_a_stage_codes,
    input  wire logic [pab_pkg::RAW_W-1:0]          chan_b_stage_codes,
    // Downstream capture handshake.
    input  wire logic                               capture_ready,
    // Internal two-phase clock to the analog stages.
    output logic                                    phase_sample,
    output logic                                    phase_hold,
    // Sample words and status.
    output logic [pab_pkg::WORD_W-1:0]              chan_a_output_bits,
    output logic [pab_pkg::WORD_W-1:0]              chan_b_output_bits,
    output logic                                    word_strobe,
    output logic                                    data_valid,
    output logic                                    overrun
);
    import pab_pkg::*;

    typedef struct packed {
        pab_phase_t                                              seq;
        logic                                                    ph_sample;
        logic                                                    ph_hold;
        logic [CHANNELS-1:0][STAGES-1:0][LINE_DEPTH-1:0][CODE_W-1:0] line;
        logic [CHANNELS-1:0][WORD_W-1:0]                         corr;
        logic [CHANNELS-1:0][WORD_W-1:0]                         out_word;
        logic                                                    out_strobe;
        logic                                                    out_valid;
        logic                                                    overrun;
        logic [4:0]                                              warm_cnt;
    } pab_state_t;

    pab_state_t                      st_ff;
    pab_state_t                      nxt_st;
    logic [CHANNELS-1:0][RAW_W-1:0]  aligned;
    logic [CHANNELS-1:0][RAW_W-1:0]  codes_in;
    logic                            sample_end;
    logic                            hold_end;
    logic                            fifo_in_ready;
    logic                            fifo_out_valid;
    logic                            fifo_out_ready;
    logic [2*WORD_W-1:0]             fifo_out_data;

    // -----------------------------------------------------------------
    // Error correction
    // -----------------------------------------------------------------

    // Stage i weighs 2^(8-i); the ninth flash code adds directly. Code 3 from a
    // redundant stage is an impossible decision and is pulled back to 2.
    function automatic logic [WORD_W-1:0] pab_correct(input logic [RAW_W-1:0] raw);
        logic [WORD_W:0] acc;
        logic [1:0]      c;
        acc = '0;
        c   = '0;
        for (int i = 0; i < STAGES - 1; i++) begin
            c = raw[CODE_W*i +: CODE_W];
            if (c == CODE_TOP) begin
                c = CODE_MAX;
            end
            acc = acc + ((WORD_W+1)'(c) << (STAGES - 1 - i));
        end
        acc = acc + (WORD_W+1)'(raw[RAW_W-1 -: CODE_W]);
        return acc[WORD_W-1:0];
    endfunction

    // -----------------------------------------------------------------
    // Next state
    // -----------------------------------------------------------------
    assign codes_in[0]    = chan_a_stage_codes;
    assign codes_in[1]    = chan_b_stage_codes;
    // Phase ends follow the registered phases: reset leaves the sequencer in its
    // sample state with the phase low, and that must not count as a sample end.
    assign sample_end     = st_ff.ph_sample;
    assign hold_end       = st_ff.ph_hold;
    assign fifo_out_ready = sample_end && capture_ready;

    // The gap states keep the phases apart by a full core clock each way.
    always_comb begin
        nxt_st  = st_ff;
        aligned = '0;
        case (st_ff.seq)
            PH_SAMPLE: nxt_st.seq = PH_GAP_A;
            PH_GAP_A:  nxt_st.seq = PH_HOLD;
            PH_HOLD:   nxt_st.seq = PH_GAP_B;
            PH_GAP_B:  nxt_st.seq = PH_SAMPLE;
            default:   nxt_st.seq = PH_SAMPLE;
        endcase
        nxt_st.ph_sample = (nxt_st.seq == PH_SAMPLE);
        nxt_st.ph_hold   = (nxt_st.seq == PH_HOLD);

        // Every phase end shifts all lines; the tap only reads entries that
        // were taken at the end of the stage's own phase.
        if (sample_end || hold_end) begin
            for (int ch = 0; ch < CHANNELS; ch++) begin
                for (int s = 0; s < STAGES; s++) begin
                    nxt_st.line[ch][s] = {st_ff.line[ch][s][LINE_DEPTH-2:0],
                                          codes_in[ch][CODE_W*s +: CODE_W]};
                end
            end
        end

        // Stage s of a sample was taken 8-s half cycles before the ninth stage.
        for (int ch = 0; ch < CHANNELS; ch++) begin
            for (int s = 0; s < STAGES; s++) begin
                aligned[ch][CODE_W*s +: CODE_W] = nxt_st.line[ch][s][STAGES-1-s];
            end
        end
        if (hold_end) begin
            for (int ch = 0; ch < CHANNELS; ch++) begin
                nxt_st.corr[ch] = pab_correct(aligned[ch]);
            end
        end

        // Output register loads both channels from one FIFO word.
        nxt_st.out_strobe = 1'b0;
        if (fifo_out_ready && fifo_out_valid) begin
            nxt_st.out_word   = fifo_out_data;
            nxt_st.out_strobe = 1'b1;
            nxt_st.out_valid  = (st_ff.warm_cnt == WARMUP_CYCLES);
        end
        if (sample_end && st_ff.warm_cnt != WARMUP_CYCLES) begin
            nxt_st.warm_cnt = st_ff.warm_cnt + 1'b1;
        end
        // A stalled reader cannot stop the converter; lost words are flagged.
        if (sample_end && !fifo_in_ready) begin
            nxt_st.overrun = 1'b1;
        end
    end

    // State register.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // -----------------------------------------------------------------
    // Output buffer
    // -----------------------------------------------------------------

    // Words enter at the sample end two core cycles after correction so the output lands after cycle six.
    pab_fifo #(
        .WIDTH (2*WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .in_valid  (sample_end),
        .in_ready  (fifo_in_ready),
        .in_data   (st_ff.corr),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    // Outputs, all straight from the state register.
    assign phase_sample       = st_ff.ph_sample;
    assign phase_hold         = st_ff.ph_hold;
    assign chan_a_output_bits = st_ff.out_word[0];
    assign chan_b_output_bits = st_ff.out_word[1];
    assign word_strobe        = st_ff.out_strobe;
    assign data_valid         = st_ff.out_valid;
    assign overrun            = st_ff.overrun;

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // Phase sequencer: the two phases never meet and keep one gap cycle each way.
    a_phase_overlap: assert property (!(phase_sample && phase_hold))
        else $error("Sample and hold phases overlap.");
    a_hold_follows: assert property ($fell(phase_sample) |-> !phase_hold ##1 phase_hold)
        else $error("Hold phase did not follow the end of sampling.");
    a_hold_gap: assert property ($fell(phase_hold) |-> !phase_sample ##1 phase_sample)
        else $error("Sample phase did not follow the hold gap.");
    a_stage_alternate: assert property (phase_sample |-> ##2 phase_hold ##2 phase_sample)
        else $error("Stage phases do not alternate.");

    // Delay line and correction; the corner codes expose a wrong stage weight at once.
    a_line_advance: assert property (sample_end |=> st_ff.line[1][0][1] == $past(st_ff.line[1][0][0]))
        else $error("Delay line did not advance.");
    a_word_align: assert property (hold_end |-> aligned[0][1:0] == st_ff.line[0][0][STAGES-2])
        else $error("First stage code misaligned.");
    a_corr_full: assert property ((hold_end && aligned[0] == '1) |=> st_ff.corr[0] == WORD_FULL)
        else $error("Full scale code not corrected to all ones.");
    a_mid_code: assert property ((hold_end && aligned[1] == 18'h0_0002) |=> st_ff.corr[1] == WORD_MID)
        else $error("Midscale code wrong.");

    // Output stream: latency, rate, pairing and warm-up gating.
    a_fixed_latency: assert property ((sample_end && !fifo_out_valid && capture_ready)
        ##1 capture_ready[*4] |=> chan_a_output_bits == $past(st_ff.corr[0], 5))
        else $error("Output latency is not six cycles.");
    a_word_rate: assert property (word_strobe |=> !word_strobe[*3])
        else $error("Output words closer than one sampling cycle.");
    a_strobe_sample: assert property (word_strobe |-> $past(sample_end))
        else $error("Output word loaded away from a sample end.");
    a_pair_update: assert property (($changed(chan_a_output_bits) || $changed(chan_b_output_bits))
        |-> word_strobe)
        else $error("Channel words changed outside an output update.");
    a_pair_source: assert property (word_strobe |->
        chan_b_output_bits == $past(fifo_out_data[2*WORD_W-1:WORD_W]))
        else $error("Channel b word not taken from the same buffer entry.");
    a_warm_gate: assert property (data_valid |-> st_ff.warm_cnt == WARMUP_CYCLES)
        else $error("Data marked valid before warm-up ended.");
    a_valid_sticky: assert property (data_valid |=> data_valid)
        else $error("Valid flag dropped without a reset.");

    // -----------------------------------------------------------------
    // Cover points
    // -----------------------------------------------------------------
    // A stall with words waiting is the only way the buffer backlog can grow.
    c_valid_word: cover property (word_strobe && data_valid);
    c_overrun: cover property ($rose(overrun));
    c_full_scale: cover property (hold_end && aligned[0] == '1);
    c_mid_scale: cover property (hold_end && aligned[1] == 18'h0_0002);
    c_stall_wait: cover property (sample_end && !capture_ready && fifo_out_valid);
endmodule
`default_nettype wire

//--- verilog/pab_fifo.sv
// Word FIFO with valid and ready on both sides.
`timescale 1ns/10ps
`default_nettype none
module pab_fifo #(
    parameter int unsigned WIDTH = 20,
    parameter int unsigned DEPTH = 16
) (
    // Clock and reset.
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    // Filling side.
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Draining side.
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int unsigned AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr_ptr;
        logic [AW-1:0]               rd_ptr;
        logic [AW:0]                 count;
    } pab_fifo_state_t;

    pab_fifo_state_t st_ff;
    pab_fifo_state_t nxt_st;
    logic            push;
    logic            pop;

    // Flags come straight from the count, so full and empty never lie.
    assign in_ready  = (st_ff.count != (AW+1)'(DEPTH));
    assign out_valid = (st_ff.count != '0);
    assign out_data  = st_ff.mem[st_ff.rd_ptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Pointer and count update; a push and pop together leave the count alone.
    always_comb begin
        nxt_st = st_ff;
        if (push) begin
            nxt_st.mem[st_ff.wr_ptr] = in_data;
            nxt_st.wr_ptr            = st_ff.wr_ptr + 1'b1;
        end
        if (pop) begin
            nxt_st.rd_ptr = st_ff.rd_ptr + 1'b1;
        end
        if (push && !pop) begin
            nxt_st.count = st_ff.count + 1'b1;
        end else if (pop && !push) begin
            nxt_st.count = st_ff.count - 1'b1;
        end
    end

    // State register.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule
`default_nettype wire
